/* rtl/can_mode_ctrl.sv */
// Mode control and control registers of the CAN controller
//
// Function
// R1: New mode taken from requested field writes
// R2: Current mode readable at bits 7:5
// R3: Mode change waits for 11 recessive bits
// R4: Six operating modes supported
// R5: CAN 1.2, 2.0A/B, 0-8 data bytes
// R6: Bit rate up to 1 Mbit/s
// R7: Remote requests answered automatically
// R8: Up to eight transmit buffers, abortable
// R9: Up to 32 receive buffers
// R10: Up to 16 full acceptance filters
// R11: Three full acceptance masks
// R12: Store only error-free, filter-accepted frames
// R13: Wake-up detection through low-pass filter
// R14: Loopback receives own transmitted frames
// R15: Interrupt raised for every error state
// R16: Reception event to capture unit two
// R17: Window select picks filter or buffer window
// R18: Fieldbus bit count limits compared data bits
// R19: Seven-bit interrupt source code, 1000000 none
// R20: FIFO start selects buffer 0 to 31
// R21: Mode codes fixed, reset to configuration
// R22: Abort-all cleared once all aborted
// R23: Buffer space size codes, 111 reserved
// R24: Clock select doubles module clock
//
// The register offsets and strobed register access were decided locally.
`default_nettype none
module can_mode_ctrl #(
	parameter int TX_BUFS = 8,
	parameter int RX_BUFS = 32,
	parameter int FILTERS = 16,
	parameter int MASKS = 3,
	parameter int BIT_CYC = can_mode_pkg::BIT_CYCLES,
	parameter int WAKE_CYC = can_mode_pkg::WAKE_FILT_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [can_mode_pkg::ADDR_W-1:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	input wire logic canRx,
	input wire logic engineTx,
	output logic canTx,
	output logic engineRx,
	input wire logic remoteReq,
	output logic remoteReply,
	input wire logic frameDone,
	input wire logic frameErrFree,
	input wire logic filterHit,
	input wire logic [4:0] matchingFilterNumber,
	output logic storeFrame,
	output logic captureUnitTwo,
	input wire can_mode_pkg::irq_events_t events,
	output logic errIrq,
	input wire logic allTxAborted,
	output logic [TX_BUFS-1:0] abortTx,
	output logic [2:0] currentOpMode,
	output logic moduleClockSelect,
	output logic haltInIdle,
	output logic sfrWindowSelect,
	output logic wakeDetect,
	output logic [4:0] fieldbusFilterBitCount,
	output logic [2:0] bufferSpaceSize,
	output logic [4:0] fifoStartBuffer
);
	import can_mode_pkg::*;
	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// R8 R9 R10 R11 capacity limits
	if (TX_BUFS < 1 || TX_BUFS > 8) begin : g_badTx
		$error("TX_BUFS out of range");
	end
	if (RX_BUFS < 1 || RX_BUFS > 32) begin : g_badRx
		$error("RX_BUFS out of range");
	end
	if (FILTERS < 1 || FILTERS > 16 || MASKS < 1 || MASKS > 3) begin : g_badF
		$error("filter or mask count out of range");
	end
	// R6 bit time no shorter than 1 Mbit/s
	if (BIT_CYC < BIT_CYCLES || WAKE_CYC < 1) begin : g_badT
		$error("bit time or wake filter too short");
	end
	localparam int IDLE_CYC = IDLE_BITS * BIT_CYC;
	localparam int IDLE_W = $clog2(IDLE_CYC + 1);
	localparam int WAKE_W = $clog2(WAKE_CYC + 1);
	localparam logic [IDLE_W-1:0] IDLE_LIM = IDLE_W'(IDLE_CYC);
	localparam logic [WAKE_W-1:0] WAKE_LIM = WAKE_W'(WAKE_CYC);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	mode_ctrl_t ctrl_q, ctrl_d;
	op_mode_t curMode_q;
	logic [4:0] fbfCount_q;
	logic [2:0] bufSize_q;
	logic [4:0] fifoStart_q;
	logic [15:0] rdata_q;
	logic rxMeta_q, rxSync_q;
	logic [IDLE_W-1:0] idleCnt_q;
	logic [WAKE_W-1:0] wakeCnt_q;
	logic wake_q;
	logic canTx_q, engineRx_q, remote_q, store_q, cap_q, err_q;
	logic [TX_BUFS-1:0] abort_q;
	logic [4:0] matching_filter_number_q;
	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	// Write strobes for the mode, FBF and FIFO registers
	wire logic wrMode = regWr && regAddr == REG_MODE;
	wire logic wrFbf = regWr && regAddr == REG_FBF;
	wire logic wrFifo = regWr && regAddr == REG_FIFO;
	wire logic [2:0] wReq = regWdata[REQ_LSB+:3];
	wire logic [4:0] wFbf = regWdata[4:0];
	wire logic [2:0] wBsz = regWdata[BSZ_LSB+:3];
	// Reserved mode codes are refused
	wire logic reqOk = wReq != MODE_RSV5 && wReq != MODE_RSV6;
	// Next value of the mode control fields
	always_comb begin
		ctrl_d = ctrl_q;
		if (wrMode) begin
			ctrl_d.halt = regWdata[HALT_BIT];
			ctrl_d.clkSel = regWdata[CKS_BIT];
			ctrl_d.capEn = regWdata[CAP_BIT];
			ctrl_d.winSel = regWdata[WIN_BIT];
			// R1 R21 request only on write
			if (reqOk) begin
				ctrl_d.reqMode = wReq;
			end
		end
		// R22 hardware clears abort request
		if (allTxAborted) begin
			ctrl_d.abortAll = 1'b0;
		end
		// Software set wins over clear
		if (wrMode && regWdata[ABORT_BIT]) begin
			ctrl_d.abortAll = 1'b1;
		end
	end
	// Mode control register
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= '{halt: 1'b0, abortAll: 1'b0, clkSel: 1'b0,
				reqMode: MODE_RESET, capEn: 1'b0, winSel: 1'b0};
		end else begin
			ctrl_q <= ctrl_d;
		end
	end
	// ----------------------------------------------------------------
	// Bus idle detection
	// ----------------------------------------------------------------
	// Two-stage synchroniser for the receive pin
	always_ff @(posedge clk) begin
		if (srst) begin
			rxMeta_q <= 1'b1;
			rxSync_q <= 1'b1;
		end else begin
			rxMeta_q <= canRx;
			rxSync_q <= rxMeta_q;
		end
	end
	// R3 count recessive time, saturating
	wire logic busIdle = idleCnt_q == IDLE_LIM;
	always_ff @(posedge clk) begin
		if (srst || !rxSync_q) begin
			idleCnt_q <= '0;
		end else if (!busIdle) begin
			idleCnt_q <= idleCnt_q + IDLE_W'(1);
		end
	end
	// ----------------------------------------------------------------
	// Current mode
	// ----------------------------------------------------------------
	// R3 R2 switch only when bus idle
	wire logic modeDiff = ctrl_q.reqMode != curMode_q;
	always_ff @(posedge clk) begin
		if (srst) begin
			curMode_q <= MODE_RESET;
		end else if (modeDiff && busIdle) begin
			curMode_q <= op_mode_t'(ctrl_q.reqMode);
		end
	end
	// ----------------------------------------------------------------
	// Bus path per mode
	// ----------------------------------------------------------------
	// R4 R14 driving and loopback by mode
	wire logic isLoop = curMode_q == MODE_LOOPBACK;
	wire logic isNormal = curMode_q == MODE_NORMAL;
	wire logic canRecv = isNormal || isLoop || curMode_q == MODE_LISTEN
		|| curMode_q == MODE_LISTEN_ALL;
	wire logic txBit = isNormal ? engineTx : 1'b1;
	wire logic rxBit = isLoop ? engineTx : rxSync_q;
	// Pin and engine path registers
	always_ff @(posedge clk) begin
		if (srst) begin
			canTx_q <= 1'b1;
			engineRx_q <= 1'b1;
		end else begin
			canTx_q <= txBit;
			engineRx_q <= canRecv ? rxBit : 1'b1;
		end
	end
	// ----------------------------------------------------------------
	// Reception events
	// ----------------------------------------------------------------
	// R12 R5 clean, matched frames, any format
	wire logic accept = frameDone && frameErrFree && filterHit && canRecv;
	// R7 answer remote requests in normal and loopback modes
	wire logic answer = remoteReq && (isNormal || isLoop);
	// R16 timestamp pulse on reception
	wire logic capture = accept && ctrl_q.capEn;
	always_ff @(posedge clk) begin
		if (srst) begin
			store_q <= 1'b0;
			remote_q <= 1'b0;
			cap_q <= 1'b0;
			matching_filter_number_q <= '0;
		end else begin
			store_q <= accept;
			remote_q <= answer;
			cap_q <= capture;
			if (accept) begin
				matching_filter_number_q <= matchingFilterNumber;
			end
		end
	end
	// ----------------------------------------------------------------
	// Wake-up filter
	// ----------------------------------------------------------------
	// R13 dominant must persist through the filter
	wire logic sleeping = curMode_q == MODE_DISABLE;
	wire logic wakeHit = wakeCnt_q == WAKE_LIM;
	always_ff @(posedge clk) begin
		if (srst || rxSync_q || !sleeping) begin
			wakeCnt_q <= '0;
		end else if (!wakeHit) begin
			wakeCnt_q <= wakeCnt_q + WAKE_W'(1);
		end
	end
	// One pulse as the filter count is reached
	wire logic wakeRise = sleeping && !rxSync_q
		&& wakeCnt_q == WAKE_LIM - WAKE_W'(1);
	always_ff @(posedge clk) begin
		if (srst) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= wakeRise;
		end
	end
	// ----------------------------------------------------------------
	// Abort fan-out and error line
	// ----------------------------------------------------------------
	// R8 R22 every transmit buffer aborts
	genvar gi;
	for (gi = 0; gi < TX_BUFS; gi++) begin : g_abort
		always_ff @(posedge clk) begin
			if (srst) begin
				abort_q[gi] <= 1'b0;
			end else begin
				abort_q[gi] <= ctrl_q.abortAll;
			end
		end
	end
	// R15 any error state raises the line
	always_ff @(posedge clk) begin
		if (srst) begin
			err_q <= 1'b0;
		end else begin
			err_q <= events.errPending;
		end
	end
	// ----------------------------------------------------------------
	// Interrupt source code
	// ----------------------------------------------------------------
	// Lowest pending receive buffer
	logic [6:0] rbCode;
	logic rbAny;
	always_comb begin
		rbCode = INTERRUPT_SOURCE_CODE_NONE;
		rbAny = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (events.rxBufFull[i]) begin
				rbCode = 7'(i);
				rbAny = 1'b1;
			end
		end
	end

	// R19 fixed priority, none when idle
	wire logic wakeAny = events.wakePending || wake_q;
	wire logic [6:0] interrupt_source_code = events.errPending ? INTERRUPT_SOURCE_CODE_ERR
		: wakeAny ? INTERRUPT_SOURCE_CODE_WAKE
		: events.overflow ? INTERRUPT_SOURCE_CODE_OVF
		: events.fifoAlmostFull ? INTERRUPT_SOURCE_CODE_FIFO
		: rbAny ? rbCode : INTERRUPT_SOURCE_CODE_NONE;
	// ----------------------------------------------------------------
	// Fieldbus filter and FIFO control
	// ----------------------------------------------------------------
	// R18 invalid counts refused
	wire logic fbfOk = wFbf <= FBF_MAX;
	// R23 reserved size code refused
	wire logic bszOk = wBsz != BSZ_RSV;
	always_ff @(posedge clk) begin
		if (srst) begin
			fbfCount_q <= '0;
			bufSize_q <= '0;
			fifoStart_q <= '0;
		end else begin
			if (wrFbf && fbfOk) begin
				fbfCount_q <= wFbf;
			end
			if (wrFifo && bszOk) begin
				bufSize_q <= wBsz;
			end
			// R20 any start buffer 0..31
			if (wrFifo) begin
				fifoStart_q <= regWdata[4:0];
			end
		end
	end
	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// R2 R17 read images of each register
	wire logic [15:0] modeImg = {2'h0, ctrl_q.halt, ctrl_q.abortAll,
		ctrl_q.clkSel, ctrl_q.reqMode, curMode_q, 1'b0, ctrl_q.capEn,
		2'h0, ctrl_q.winSel};
	wire logic [15:0] fbfImg = {11'h000, fbfCount_q};
	wire logic [15:0] isrcImg = {3'h0, matching_filter_number_q, 1'b0, interrupt_source_code};
	wire logic [15:0] fifoImg = {bufSize_q, 8'h00, fifoStart_q};
	wire logic [15:0] rdSel = regAddr == REG_MODE ? modeImg
		: regAddr == REG_FBF ? fbfImg
		: regAddr == REG_ISRC ? isrcImg
		: regAddr == REG_FIFO ? fifoImg : 16'h0000;

	// Read data for one cycle after the strobe
	always_ff @(posedge clk) begin
		if (srst || !regRd) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdSel;
		end
	end
	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// R24 clock select handed to clock tree
	assign moduleClockSelect = ctrl_q.clkSel;
	assign haltInIdle = ctrl_q.halt;
	// R17 window select
	assign sfrWindowSelect = ctrl_q.winSel;
	assign currentOpMode = curMode_q;
	assign regRdata = rdata_q;
	assign canTx = canTx_q;
	assign engineRx = engineRx_q;
	assign remoteReply = remote_q;
	assign storeFrame = store_q;
	assign captureUnitTwo = cap_q;
	assign errIrq = err_q;
	assign abortTx = abort_q;
	assign wakeDetect = wake_q;
	assign fieldbusFilterBitCount = fbfCount_q;
	assign bufferSpaceSize = bufSize_q;
	assign fifoStartBuffer = fifoStart_q;
endmodule
`default_nettype wire

/* rtl/can_mode_pkg.sv */
// Constants, codes and carrier types for the mode control block
`default_nettype none
package can_mode_pkg;
	// ----------------------------------------------------------------
	// Register map (word indices)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 3;
	localparam logic [2:0] REG_MODE = 3'h0;
	localparam logic [2:0] REG_FBF = 3'h1;
	localparam logic [2:0] REG_ISRC = 3'h2;
	localparam logic [2:0] REG_FIFO = 3'h3;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int HALT_BIT = 13;
	localparam int ABORT_BIT = 12;
	localparam int CKS_BIT = 11;
	localparam int REQ_LSB = 8;
	localparam int CUR_LSB = 5;
	localparam int CAP_BIT = 3;
	localparam int WIN_BIT = 0;
	localparam int MATCHING_FILTER_NUMBER_LSB = 8;
	localparam int BSZ_LSB = 13;
	// ----------------------------------------------------------------
	// Operating modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b000,
		MODE_DISABLE = 3'b001,
		MODE_LOOPBACK = 3'b010,
		MODE_LISTEN = 3'b011,
		MODE_CONFIG = 3'b100,
		MODE_RSV5 = 3'b101,
		MODE_RSV6 = 3'b110,
		MODE_LISTEN_ALL = 3'b111
	} op_mode_t;
	localparam op_mode_t MODE_RESET = MODE_CONFIG;
	// ----------------------------------------------------------------
	// Interrupt source codes and field limits
	// ----------------------------------------------------------------
	localparam logic [6:0] INTERRUPT_SOURCE_CODE_NONE = 7'h40;
	localparam logic [6:0] INTERRUPT_SOURCE_CODE_ERR = 7'h41;
	localparam logic [6:0] INTERRUPT_SOURCE_CODE_WAKE = 7'h42;
	localparam logic [6:0] INTERRUPT_SOURCE_CODE_OVF = 7'h43;
	localparam logic [6:0] INTERRUPT_SOURCE_CODE_FIFO = 7'h44;
	localparam logic [4:0] FBF_MAX = 5'h11;
	localparam logic [2:0] BSZ_RSV = 3'h7;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int BIT_RATE_KBPS = 1000;
	localparam int BIT_CYCLES = CLK_MHZ * 1000 / BIT_RATE_KBPS;
	localparam int IDLE_BITS = 11;
	localparam int WAKE_FILT_NS = 500;
	localparam int WAKE_FILT_CYC = (WAKE_FILT_NS * CLK_MHZ + 999) / 1000;
	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic halt;
		logic abortAll;
		logic clkSel;
		logic [2:0] reqMode;
		logic capEn;
		logic winSel;
	} mode_ctrl_t;
	typedef struct packed {
		logic errPending;
		logic wakePending;
		logic overflow;
		logic fifoAlmostFull;
		logic [15:0] rxBufFull;
	} irq_events_t;
endpackage
`default_nettype wire

/* tb/can_bus_node.sv */
// Behavioural model of another node sharing the CAN bus
`default_nettype none
module can_bus_node #(
	parameter int BIT = 100
) (
	input wire logic clk,
	input wire logic busy,
	input wire logic canTx,
	output logic canRx
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	logic nodeBit = 1'b1;
	// Wired-AND bus, dominant from either node wins
	assign canRx = canTx & nodeBit;
	// While busy, alternate bits so the bus never looks idle
	always @(posedge clk) begin
		if (!busy) begin
			nodeBit <= 1'b1;
			cnt <= 0;
		end else if (cnt == BIT - 1) begin
			nodeBit <= ~nodeBit;
			cnt <= 0;
		end else
			cnt <= cnt + 1;
	end
endmodule
`default_nettype wire

/* tb/can_mode_ctrl_sva.sv */
// Port-level assertions for the CAN mode control block
`default_nettype none
module can_mode_ctrl_sva import can_mode_pkg::*; #(
	parameter int TX_BUFS = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic regRd,
	input wire logic regWr,
	input wire logic [15:0] regWdata,
	input wire logic [15:0] regRdata,
	input wire logic canRx,
	input wire logic engineTx,
	input wire logic canTx,
	input wire logic engineRx,
	input wire logic remoteReq,
	input wire logic remoteReply,
	input wire logic frameDone,
	input wire logic frameErrFree,
	input wire logic filterHit,
	input wire logic storeFrame,
	input wire can_mode_pkg::irq_events_t events,
	input wire logic errIrq,
	input wire logic [TX_BUFS-1:0] abortTx,
	input wire logic [2:0] currentOpMode
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [10:0] idleCnt;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Recessive run length seen on the raw bus pin
	always_ff @(posedge clk) begin
		if (srst || !canRx)
			idleCnt <= '0;
		else if (idleCnt != 11'h7ff)
			idleCnt <= idleCnt + 11'h1;
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	reset_config_a: assert property (disable iff (1'b0)
		srst |=> currentOpMode == MODE_CONFIG) else $error("mode not config");
	mode_legal_a: assert property (
		currentOpMode != MODE_RSV5 && currentOpMode != MODE_RSV6)
		else $error("reserved mode shown");
	idle_wait_a: assert property (
		!$past(srst) && $changed(currentOpMode) |-> $past(idleCnt, 3) >= 11'd1090)
		else $error("mode changed on busy bus");
	tx_path_a: assert property (
		!$past(srst) |-> canTx == (($past(currentOpMode) == MODE_NORMAL)
		? $past(engineTx) : 1'b1)) else $error("canTx wrong");
	loop_path_a: assert property (
		!$past(srst) && $past(currentOpMode) == MODE_LOOPBACK
		|-> engineRx == $past(engineTx)) else $error("loopback path wrong");
	remote_reply_a: assert property (
		remoteReq && currentOpMode inside {MODE_NORMAL, MODE_LOOPBACK}
		|=> remoteReply) else $error("no remote reply");
	store_accept_a: assert property (
		frameDone && frameErrFree && filterHit && currentOpMode inside
		{MODE_NORMAL, MODE_LOOPBACK, MODE_LISTEN, MODE_LISTEN_ALL}
		|=> storeFrame) else $error("accepted frame not stored");
	store_cause_a: assert property (
		storeFrame |-> $past(frameDone && frameErrFree && filterHit))
		else $error("frame stored without cause");
	err_irq_a: assert property (
		!$past(srst) |-> errIrq == $past(events.errPending))
		else $error("errIrq wrong");
	abort_all_a: assert property (
		abortTx == '0 || abortTx == '1) else $error("abortTx split");
	abort_start_a: assert property (
		$rose(abortTx[0]) |-> $past(regWr, 2) && $past(regWdata[ABORT_BIT], 2))
		else $error("abort without write");
	read_idle_a: assert property (
		!$past(regRd) |-> regRdata == 16'h0) else $error("regRdata not idle");
	cover property (currentOpMode == MODE_LOOPBACK);
	cover property (storeFrame);
	cover property (abortTx[0]);
endmodule
bind can_mode_ctrl can_mode_ctrl_sva #(.TX_BUFS(TX_BUFS)) sva (.clk, .srst,
	.regRd, .regWr, .regWdata, .regRdata, .canRx, .engineTx, .canTx,
	.engineRx, .remoteReq, .remoteReply, .frameDone, .frameErrFree,
	.filterHit, .storeFrame, .events, .errIrq, .abortTx, .currentOpMode);
`default_nettype wire

/* tb/can_mode_ctrl_test.sv */
// Self-checking bench for the CAN mode control block
`default_nettype none
module can_mode_ctrl_test import can_mode_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, srst, regWr, regRd, canRx, engineTx, canTx, engineRx, busy;
	logic remoteReq, remoteReply, frameDone, frameErrFree, filterHit;
	logic storeFrame, captureUnitTwo, errIrq, allTxAborted, wakeDetect;
	logic moduleClockSelect, haltInIdle, sfrWindowSelect;
	logic [2:0] regAddr, currentOpMode, bufferSpaceSize;
	logic [15:0] regWdata, regRdata;
	logic [4:0] matchingFilterNumber, fieldbusFilterBitCount, fifoStartBuffer;
	logic [7:0] abortTx;
	irq_events_t events;
	int errors, checked, cycles, n;
	logic [19:0] evTab [5] = '{20'h90000, 20'h60000, 20'h30000, 20'h10a00,
		20'h00a00};
	logic [6:0] codeTab [5] = '{7'h41, 7'h42, 7'h43, 7'h44, 7'h09};
	can_mode_ctrl #(.WAKE_CYC(4)) DUT (.clk, .srst, .regAddr, .regWdata,
		.regWr, .regRd, .regRdata, .canRx, .engineTx, .canTx, .engineRx,
		.remoteReq, .remoteReply, .frameDone, .frameErrFree, .filterHit,
		.matchingFilterNumber, .storeFrame, .captureUnitTwo, .events, .errIrq,
		.allTxAborted, .abortTx, .currentOpMode, .moduleClockSelect,
		.haltInIdle, .sfrWindowSelect, .wakeDetect, .fieldbusFilterBitCount,
		.bufferSpaceSize, .fifoStartBuffer);
	can_bus_node #(.BIT(100)) node (.clk, .busy, .canTx, .canRx);
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [15:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(logic [2:0] a, logic [15:0] exp);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk("regRdata", exp, regRdata);
	endtask
	task automatic waitMode(op_mode_t m);
		for (n = 0; n < 3000 && currentOpMode !== m; n++) begin
			@(posedge clk);
			#1;
		end
		chk("currentOpMode", 16'(m), 16'(currentOpMode));
	endtask
	task automatic txBit(logic expTx, logic expRx);
		@(posedge clk);
		engineTx <= 1'b0;
		@(posedge clk);
		engineTx <= 1'b1;
		#1 chk("canTx", 16'(expTx), 16'(canTx));
		chk("engineRx", 16'(expRx), 16'(engineRx));
	endtask
	task automatic frame(logic ok, logic exp, logic cap);
		@(posedge clk);
		frameDone <= 1'b1;
		frameErrFree <= ok;
		filterHit <= 1'b1;
		matchingFilterNumber <= 5'h0b;
		@(posedge clk);
		frameDone <= 1'b0;
		#1 chk("storeFrame", 16'(exp), 16'(storeFrame));
		chk("captureUnitTwo", 16'(cap), 16'(captureUnitTwo));
	endtask
	// ------------------------------------------------------------
	// Clock, timeout and sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		{srst, busy, engineTx} = 3'b101;
		{regWr, regRd, remoteReq, frameDone, frameErrFree, filterHit} = '0;
		{regAddr, regWdata, matchingFilterNumber, allTxAborted} = '0;
		events = '0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rd(REG_MODE, 16'h0480);
		rd(REG_FBF, 16'h0000);
		rd(REG_ISRC, 16'h0040);
		rd(REG_FIFO, 16'h0000);
		rd(3'h5, 16'h0000);
		busy <= 1'b1;
		wr(REG_MODE, 16'h0008);
		rd(REG_MODE, 16'h0088);
		repeat (1500) @(posedge clk);
		#1 chk("currentOpMode", 16'h4, 16'(currentOpMode));
		busy <= 1'b0;
		waitMode(MODE_NORMAL);
		rd(REG_MODE, 16'h0008);
		wr(REG_MODE, 16'h0508);
		rd(REG_MODE, 16'h0008);
		txBit(1'b0, 1'b1);
		frame(1'b1, 1'b1, 1'b1);
		rd(REG_ISRC, 16'h0b40);
		frame(1'b0, 1'b0, 1'b0);
		@(posedge clk);
		remoteReq <= 1'b1;
		@(posedge clk);
		remoteReq <= 1'b0;
		#1 chk("remoteReply", 16'h1, 16'(remoteReply));
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			events <= evTab[i];
			rd(REG_ISRC, {8'h0b, 1'b0, codeTab[i]});
			chk("errIrq", 16'(evTab[i][19]), 16'(errIrq));
		end
		events <= '0;
		wr(REG_MODE, 16'h1008);
		@(posedge clk);
		#1 chk("abortTx", 16'h00ff, 16'(abortTx));
		rd(REG_MODE, 16'h1008);
		@(posedge clk);
		allTxAborted <= 1'b1;
		@(posedge clk);
		allTxAborted <= 1'b0;
		rd(REG_MODE, 16'h0008);
		chk("abortTx", 16'h0000, 16'(abortTx));
		wr(REG_FBF, 16'h0011);
		rd(REG_FBF, 16'h0011);
		wr(REG_FBF, 16'h0012);
		rd(REG_FBF, 16'h0011);
		chk("fbfCount", 16'h0011, 16'(fieldbusFilterBitCount));
		wr(REG_FIFO, 16'hc01f);
		rd(REG_FIFO, 16'hc01f);
		chk("fifoStart", 16'h001f, 16'(fifoStartBuffer));
		wr(REG_FIFO, 16'he000);
		rd(REG_FIFO, 16'hc000);
		chk("bufSize", 16'h0006, 16'(bufferSpaceSize));
		wr(3'h6, 16'hffff);
		rd(3'h6, 16'h0000);
		wr(REG_MODE, 16'h0200);
		waitMode(MODE_LOOPBACK);
		txBit(1'b1, 1'b0);
		frame(1'b1, 1'b1, 1'b0);
		wr(REG_MODE, 16'h2901);
		waitMode(MODE_DISABLE);
		frame(1'b1, 1'b0, 1'b0);
		rd(REG_MODE, 16'h2921);
		chk("clkSel", 16'h1, 16'(moduleClockSelect));
		chk("winSel", 16'h1, 16'(sfrWindowSelect));
		chk("halt", 16'h1, 16'(haltInIdle));
		busy <= 1'b1;
		for (n = 0; n < 400 && wakeDetect !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk("wakeDetect", 16'h1, 16'(wakeDetect));
		busy <= 1'b0;
		finish_test();
	end
endmodule
`default_nettype wire
